// *** common/phymt_pkg.sv ***
`default_nettype none
package phymt_pkg;
	localparam real CLK_NS = 100.0;
	localparam real BT10_NS = 100.0;
	localparam real BT100_NS = 10.0;
	localparam real NS_PER_US = 1000.0;
	localparam real NS_PER_MS = 1000000.0;

	// Least times round up, longest times round down, never below one cycle
	function automatic int cyc_up(input real ns);
		int c;
		c = int'($ceil(ns / CLK_NS));
		return (c < 1) ? 1 : c;
	endfunction
	function automatic int cyc_dn(input real ns);
		int c;
		c = int'($floor(ns / CLK_NS));
		return (c < 1) ? 1 : c;
	endfunction

	localparam real FX_DATA_MIN_BT = 3.0;
	localparam real FX_CRS_ON_MIN_BT = 9.0;
	localparam real FX_CRS_OFF_MIN_BT = 13.0;
	localparam real FX_COL_ON_MIN_BT = 10.0;
	localparam real FX_COL_OFF_MIN_BT = 13.0;
	localparam real TX_CRS_ON_BT = 5.5;
	localparam real TX_CRS_OFF_BT = 5.0;
	localparam real TX_LAT_NS = 575.0;
	localparam real RX_SFD_BT = 62.0;
	localparam real RX_ACT_BT = 4.0;
	localparam real HB_DLY_MIN_US = 0.65;
	localparam real HB_LEN_MIN_US = 0.5;
	localparam real JAB_MIN_MS = 20.0;
	localparam real UNJAB_MIN_MS = 250.0;
	localparam real FLP_PW_MIN_NS = 115.0;
	localparam real FLP_DATA_MIN_US = 55.5;
	localparam real FLP_CLK_MIN_US = 111.0;
	localparam real FLP_BURST_MIN_MS = 8.0;
	localparam real BOOT_MAX_US = 300.0;

	localparam int FLP_BITS = 16;
	localparam int RX_FIFO_DEPTH = 16;
	localparam int NIB_W = 4;

	localparam logic [31:0] FX_DATA_CYC = 32'(cyc_up(FX_DATA_MIN_BT * BT100_NS));
	localparam logic [31:0] RX_SFD_CYC = 32'(cyc_up(RX_SFD_BT * BT10_NS));
	localparam logic [31:0] HB_DLY_CYC = 32'(cyc_up(HB_DLY_MIN_US * NS_PER_US));
	localparam logic [31:0] HB_LEN_CYC = 32'(cyc_up(HB_LEN_MIN_US * NS_PER_US));
	localparam logic [31:0] JAB_CYC_DEF = 32'(cyc_up(JAB_MIN_MS * NS_PER_MS));
	localparam logic [31:0] UNJAB_CYC_DEF = 32'(cyc_up(UNJAB_MIN_MS * NS_PER_MS));
	localparam logic [31:0] FLP_GAP_CYC_DEF = 32'(cyc_up(FLP_BURST_MIN_MS * NS_PER_MS));
	localparam logic [31:0] FLP_PW_CYC = 32'(cyc_up(FLP_PW_MIN_NS));
	localparam logic [31:0] FLP_DATA_CYC = 32'(cyc_up(FLP_DATA_MIN_US * NS_PER_US));
	localparam logic [31:0] FLP_CLK_CYC = 32'(cyc_up(FLP_CLK_MIN_US * NS_PER_US));
	localparam logic [31:0] BOOT_CYC = 32'(cyc_dn(BOOT_MAX_US * NS_PER_US));

	// Delayed level channels
	localparam int CH_N = 6;
	localparam int CH_TXCRS = 0;
	localparam int CH_RXCRS = 1;
	localparam int CH_COL = 2;
	localparam int CH_TP = 3;
	localparam int CH_FXCRS = 4;
	localparam int CH_FXCOL = 5;
	localparam int CH_ON [CH_N] = '{cyc_up(TX_CRS_ON_BT * BT10_NS), cyc_up(RX_ACT_BT * BT10_NS),
		cyc_up(RX_ACT_BT * BT10_NS), cyc_up(TX_LAT_NS), cyc_up(FX_CRS_ON_MIN_BT * BT100_NS),
		cyc_up(FX_COL_ON_MIN_BT * BT100_NS)};
	localparam int CH_OFF [CH_N] = '{cyc_up(TX_CRS_OFF_BT * BT10_NS), cyc_up(RX_ACT_BT * BT10_NS),
		cyc_up(RX_ACT_BT * BT10_NS), cyc_up(TX_LAT_NS), cyc_up(FX_CRS_OFF_MIN_BT * BT100_NS),
		cyc_up(FX_COL_OFF_MIN_BT * BT100_NS)};

	typedef struct packed {
		logic link_clk;
		logic tx_en;
		logic rx_act;
		logic rx_col;
		logic fx_j;
		logic fx_t;
		logic rx_nib_stb;
		logic [NIB_W-1:0] rx_nib;
		logic cfg_pre;
		logic cfg_ext;
		logic sqe_en;
		logic an_en;
		logic mode_fx;
		logic [FLP_BITS-1:0] flp_word;
	} phymt_pin_type;

	typedef struct packed {
		logic crs;
		logic col;
		logic rx_dv;
		logic [NIB_W-1:0] rxd;
	} phymt_mii_type;

	typedef struct packed {
		logic tp_tx;
		logic link_pulse;
		logic jabber;
		logic mgmt_ready;
	} phymt_line_type;

	typedef enum logic [1:0] {HB_IDLE, HB_WAIT, HB_PULSE} phymt_hb_type;
	typedef enum logic [0:0] {FLP_GAP, FLP_BURST} phymt_flp_type;
endpackage
`default_nettype wire

// *** logic/phymt_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module phymt_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	// Depth must be a power of two
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wr_ff;
	logic [AW:0] rd_ff;
	logic [AW:0] fill;

	assign fill = wr_ff - rd_ff;
	assign in_ready = (fill != (AW + 1)'(DEPTH));
	assign out_valid = (fill != '0);
	assign out_data = mem_ff[rd_ff[AW-1:0]];

	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem_ff[wr_ff[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_ff <= rd_ff + 1'b1;
			end
		end
	end
endmodule // phymt_fifo
`default_nettype wire

// *** logic/phymt_core.sv ***
// Functional notes
// - FX data and valid follow carrier shortly
// - FX carrier rises after stream start
// - FX carrier falls after stream end
// - FX collision timed from stream start/end
// - 10M transmit raises and drops carrier
// - 10M line output lags transmit enable
// - 10M receive data lags line activity
// - 10M data starts at delimiter unless preamble
// - Carrier extension or half-bit tail after valid
// - 10M carrier follows line activity
// - 10M collision follows colliding activity
// - Heartbeat starts after transmit enable falls
// - Heartbeat pulse has bounded length
// - Overlong transmission enters jabber
// - Jabber holds for the unjab interval
// - Data pulse placed after clock pulse
// - Clock pulses evenly spaced in burst
// - Bursts repeat with a fixed gap
// - Seventeen to thirty-three pulses per burst
// - Management ready within recovery time
`timescale 1ns/1ps
`default_nettype none
module phymt_core #(
	parameter logic [31:0] JAB_CYC = phymt_pkg::JAB_CYC_DEF,
	parameter logic [31:0] UNJAB_CYC = phymt_pkg::UNJAB_CYC_DEF,
	parameter logic [31:0] FLP_GAP_CYC = phymt_pkg::FLP_GAP_CYC_DEF,
	parameter int FIFO_DEPTH = phymt_pkg::RX_FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire phymt_pkg::phymt_pin_type pins,
	output phymt_pkg::phymt_mii_type mii,
	output phymt_pkg::phymt_line_type line,
	output logic rx_nib_rdy
);
	import phymt_pkg::*;

	localparam int A_FXCRS_ON = CH_ON[CH_FXCRS];
	localparam int A_FXCRS_OFF = CH_OFF[CH_FXCRS];
	localparam int A_FXCOL_ON = CH_ON[CH_FXCOL];
	localparam int A_TXCRS_ON = CH_ON[CH_TXCRS];
	localparam int A_TP_ON = CH_ON[CH_TP];
	localparam int A_RXCRS_ON = CH_ON[CH_RXCRS];

	phymt_pin_type meta_ff;
	phymt_pin_type pin_ff;
	phymt_pin_type prev_ff;
	phymt_mii_type mii_ff;
	phymt_line_type line_ff;
	phymt_hb_type hb_ff;
	phymt_flp_type flp_ff;
	logic lclk_rise;
	logic fx_mode;
	logic ten_mode;
	logic tx_en_ff;
	logic tx_prev_ff;
	logic tx_fall;
	logic fx_str_ff;
	logic [CH_N-1:0] ch_in;
	logic [CH_N-1:0] ch_ff;
	logic [7:0] ch_cnt_ff [CH_N];
	logic jab_ff;
	logic [31:0] jab_cnt_ff;
	logic [31:0] hb_cnt_ff;
	logic hb_on;
	logic [31:0] flp_cnt_ff;
	logic [4:0] flp_slot_ff;
	logic flp_pulse_ff;
	logic nxt_flp_pulse;
	logic [31:0] boot_cnt_ff;
	logic rx_src;
	logic [31:0] since_ff;
	logic [31:0] start_cyc;
	logic go_ff;
	logic nxt_rx_dv;
	logic pop_en;
	logic nib_push;
	logic fifo_valid;
	logic fifo_pop;
	logic [NIB_W-1:0] fifo_data;
	logic nxt_crs;
	logic nxt_col;

	// Every pin is asynchronous to ref_clk; only pin_ff and its delayed copy prev_ff are read by logic
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_ff <= '0;
			pin_ff <= '0;
		end else begin
			meta_ff <= pins;
			pin_ff <= meta_ff;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= pin_ff;
		end
	end

	assign lclk_rise = pin_ff.link_clk & ~prev_ff.link_clk;
	assign fx_mode = pin_ff.mode_fx;
	assign ten_mode = ~pin_ff.mode_fx;
	assign nib_push = pin_ff.rx_nib_stb & ~prev_ff.rx_nib_stb;

	// Transmit enable is taken on the link clock's rising edge
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_en_ff <= 1'b0;
			tx_prev_ff <= 1'b0;
		end else begin
			tx_prev_ff <= tx_en_ff;
			if (lclk_rise) begin
				tx_en_ff <= pin_ff.tx_en;
			end
		end
	end

	assign tx_fall = tx_prev_ff & ~tx_en_ff;

	// Stream level between start and end symbols
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fx_str_ff <= 1'b0;
		end else if (pin_ff.fx_j && !prev_ff.fx_j) begin
			fx_str_ff <= 1'b1;
		end else if (pin_ff.fx_t && !prev_ff.fx_t) begin
			fx_str_ff <= 1'b0;
		end
	end

	assign ch_in[CH_TXCRS] = tx_en_ff & ten_mode;
	assign ch_in[CH_RXCRS] = pin_ff.rx_act & ten_mode;
	assign ch_in[CH_COL] = (pin_ff.rx_col | (pin_ff.rx_act & tx_en_ff)) & ten_mode;
	assign ch_in[CH_TP] = tx_en_ff & ten_mode & ~jab_ff;
	assign ch_in[CH_FXCRS] = fx_str_ff & fx_mode;
	assign ch_in[CH_FXCOL] = fx_str_ff & tx_en_ff & fx_mode;

	// Each channel follows its input only after the input held for its delay
	for (genvar i = 0; i < CH_N; i++) begin : g_ch
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				ch_ff[i] <= 1'b0;
				ch_cnt_ff[i] <= '0;
			end else if (ch_in[i] == ch_ff[i]) begin
				ch_cnt_ff[i] <= '0;
			end else if (ch_cnt_ff[i] + 8'd1 >= 8'(ch_in[i] ? CH_ON[i] : CH_OFF[i])) begin
				ch_ff[i] <= ch_in[i];
				ch_cnt_ff[i] <= '0;
			end else begin
				ch_cnt_ff[i] <= ch_cnt_ff[i] + 8'd1;
			end
		end
	end

	// Jabber watchdog and unjab hold
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			jab_ff <= 1'b0;
			jab_cnt_ff <= '0;
		end else if (jab_ff) begin
			if (jab_cnt_ff + 32'd1 >= UNJAB_CYC) begin
				jab_ff <= 1'b0;
				jab_cnt_ff <= '0;
			end else begin
				jab_cnt_ff <= jab_cnt_ff + 32'd1;
			end
		end else if (tx_en_ff && ten_mode) begin
			if (jab_cnt_ff + 32'd1 >= JAB_CYC) begin
				jab_ff <= 1'b1;
				jab_cnt_ff <= '0;
			end else begin
				jab_cnt_ff <= jab_cnt_ff + 32'd1;
			end
		end else begin
			jab_cnt_ff <= '0;
		end
	end

	// Heartbeat after each 10M transmission
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hb_ff <= HB_IDLE;
			hb_cnt_ff <= '0;
		end else begin
			case (hb_ff)
				HB_IDLE: begin
					hb_cnt_ff <= '0;
					if (tx_fall && ten_mode && pin_ff.sqe_en && !jab_ff) begin
						hb_ff <= HB_WAIT;
					end
				end
				HB_WAIT: begin
					if (hb_cnt_ff + 32'd1 >= HB_DLY_CYC) begin
						hb_ff <= HB_PULSE;
						hb_cnt_ff <= '0;
					end else begin
						hb_cnt_ff <= hb_cnt_ff + 32'd1;
					end
				end
				HB_PULSE: begin
					if (hb_cnt_ff + 32'd1 >= HB_LEN_CYC) begin
						hb_ff <= HB_IDLE;
						hb_cnt_ff <= '0;
					end else begin
						hb_cnt_ff <= hb_cnt_ff + 32'd1;
					end
				end
				default: begin
					hb_ff <= HB_IDLE;
					hb_cnt_ff <= '0;
				end
			endcase
		end
	end

	assign hb_on = (hb_ff == HB_PULSE);

	// Link pulse bursts: 17 clock slots, a data pulse in the first 16 when its bit is set
	always_ff @(posedge ref_clk) begin
		if (rst || !pin_ff.an_en || fx_mode) begin
			flp_ff <= FLP_GAP;
			flp_cnt_ff <= '0;
			flp_slot_ff <= '0;
		end else begin
			case (flp_ff)
				FLP_GAP: begin
					if (flp_cnt_ff + 32'd1 >= FLP_GAP_CYC) begin
						flp_ff <= FLP_BURST;
						flp_cnt_ff <= '0;
						flp_slot_ff <= '0;
					end else begin
						flp_cnt_ff <= flp_cnt_ff + 32'd1;
					end
				end
				FLP_BURST: begin
					if (flp_cnt_ff + 32'd1 < FLP_CLK_CYC) begin
						flp_cnt_ff <= flp_cnt_ff + 32'd1;
					end else if (flp_slot_ff == 5'(FLP_BITS)) begin
						flp_ff <= FLP_GAP;
						flp_cnt_ff <= '0;
					end else begin
						flp_slot_ff <= flp_slot_ff + 5'd1;
						flp_cnt_ff <= '0;
					end
				end
				default: begin
					flp_ff <= FLP_GAP;
					flp_cnt_ff <= '0;
				end
			endcase
		end
	end

	always_comb begin
		nxt_flp_pulse = 1'b0;
		if (flp_ff == FLP_BURST) begin
			if (flp_cnt_ff < FLP_PW_CYC) begin
				nxt_flp_pulse = 1'b1;
			end else if (flp_slot_ff < 5'(FLP_BITS) && flp_cnt_ff >= FLP_DATA_CYC &&
				flp_cnt_ff < FLP_DATA_CYC + FLP_PW_CYC) begin
				nxt_flp_pulse = pin_ff.flp_word[flp_slot_ff[3:0]];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flp_pulse_ff <= 1'b0;
		end else begin
			flp_pulse_ff <= nxt_flp_pulse;
		end
	end

	// Recovery count after reset release
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			boot_cnt_ff <= '0;
		end else if (boot_cnt_ff < BOOT_CYC) begin
			boot_cnt_ff <= boot_cnt_ff + 32'd1;
		end
	end

	// Receive path
	assign rx_src = fx_mode ? ch_ff[CH_FXCRS] : ch_ff[CH_RXCRS];
	assign start_cyc = fx_mode ? FX_DATA_CYC : (pin_ff.cfg_pre ? 32'd0 : RX_SFD_CYC);

	always_ff @(posedge ref_clk) begin
		if (rst || !rx_src) begin
			since_ff <= '0;
		end else if (since_ff < RX_SFD_CYC) begin
			since_ff <= since_ff + 32'd1;
		end
	end

	// Data keeps draining after carrier drops, so the buffer never strands a tail
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			go_ff <= 1'b0;
		end else if (rx_src && since_ff >= start_cyc) begin
			go_ff <= 1'b1;
		end else if (!rx_src && !fifo_valid) begin
			go_ff <= 1'b0;
		end
	end

	// 100 Mbps nibbles outrun ref_clk, so FX pops every cycle
	assign pop_en = fx_mode | lclk_rise;
	assign fifo_pop = go_ff & pop_en;

	phymt_fifo #(
		.WIDTH(NIB_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk(ref_clk),
		.rst(rst),
		.in_valid(nib_push),
		.in_ready(rx_nib_rdy),
		.in_data(pin_ff.rx_nib),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// Valid only moves on a pop, so carrier can follow its next value
	assign nxt_rx_dv = pop_en ? (go_ff & fifo_valid) : mii_ff.rx_dv;

	always_comb begin
		nxt_crs = ch_ff[CH_FXCRS];
		nxt_col = ch_ff[CH_FXCOL];
		if (ten_mode) begin
			nxt_crs = ch_ff[CH_TXCRS] | ch_ff[CH_RXCRS] | nxt_rx_dv;
			// Half-bit tail rounds up to one cycle
			if (!pin_ff.cfg_ext) begin
				nxt_crs = nxt_crs | mii_ff.rx_dv;
			end
			nxt_col = ch_ff[CH_COL] | hb_on | jab_ff;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mii_ff <= '0;
		end else begin
			mii_ff.crs <= nxt_crs;
			mii_ff.col <= nxt_col;
			mii_ff.rx_dv <= nxt_rx_dv;
			if (pop_en && go_ff && fifo_valid) begin
				mii_ff.rxd <= fifo_data;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			line_ff <= '0;
		end else begin
			line_ff.tp_tx <= ch_ff[CH_TP] & ~jab_ff;
			line_ff.link_pulse <= flp_pulse_ff;
			line_ff.jabber <= jab_ff;
			line_ff.mgmt_ready <= (boot_cnt_ff >= BOOT_CYC);
		end
	end

	assign mii = mii_ff;
	assign line = line_ff;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	fx_crs_on_a: assert property (
		$rose(ch_ff[CH_FXCRS]) |-> $past(ch_in[CH_FXCRS], A_FXCRS_ON)
	) else $error("fx carrier rose without stream");
	fx_crs_off_a: assert property (
		$fell(ch_ff[CH_FXCRS]) |-> !$past(ch_in[CH_FXCRS], A_FXCRS_OFF)
	) else $error("fx carrier fell early");
	fx_col_on_a: assert property (
		$rose(ch_ff[CH_FXCOL]) |-> $past(ch_in[CH_FXCOL], A_FXCOL_ON)
	) else $error("fx collision timing wrong");
	fx_data_lag_a: assert property (
		$rose(mii_ff.rx_dv) && fx_mode |-> $past(mii_ff.crs) || $past(ch_ff[CH_FXCRS], 2)
	) else $error("fx valid before carrier");
	tx_crs_on_a: assert property (
		$rose(ch_ff[CH_TXCRS]) |-> $past(ch_in[CH_TXCRS], A_TXCRS_ON)
	) else $error("tx carrier latency wrong");
	tp_latency_a: assert property (
		$rose(ch_ff[CH_TP]) |-> $past(ch_in[CH_TP], A_TP_ON)
	) else $error("line output latency wrong");
	rx_crs_on_a: assert property (
		$rose(ch_ff[CH_RXCRS]) |-> $past(ch_in[CH_RXCRS], A_RXCRS_ON)
	) else $error("rx carrier latency wrong");
	hb_start_a: assert property (
		tx_fall && ten_mode && pin_ff.sqe_en && !jab_ff && hb_ff == HB_IDLE |-> ##[7:16] hb_on
	) else $error("heartbeat late");
	hb_length_a: assert property (
		$rose(hb_on) |-> hb_on[*5] ##1 !hb_on
	) else $error("heartbeat length wrong");
	jab_mute_a: assert property (
		jab_ff |=> !line_ff.tp_tx && mii_ff.col
	) else $error("jabber not muting line");
	flp_width_a: assert property (
		$rose(flp_pulse_ff) |-> flp_pulse_ff[*2] ##1 !flp_pulse_ff
	) else $error("link pulse width wrong");
	boot_ready_a: assert property (
		$rose(line_ff.mgmt_ready) |-> $past(boot_cnt_ff, 2) == BOOT_CYC - 32'd1
	) else $error("management ready at wrong time");
endmodule // phymt_core
`default_nettype wire

// *** tb/phymt_mac_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module phymt_mac_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tx_go,
	input wire phymt_pkg::phymt_mii_type mii,
	output logic link_clk,
	output logic tx_en,
	output logic mgmt_ok
);
	import phymt_pkg::*;
	logic [NIB_W-1:0] got_q [$];
	int wait_cnt;
	// Free-running MII clock, phase unrelated to ref_clk
	initial begin
		link_clk = 1'b0;
		#137;
		forever #400 link_clk = ~link_clk;
	end
	initial tx_en = 1'b0;
	// Enable moves just after the edge that carries it, so it never races the sampler
	always @(posedge link_clk) begin
		tx_en <= tx_go;
		if (mii.rx_dv === 1'b1) begin
			got_q.push_back(mii.rxd);
		end
	end
	// Management held off for the whole recovery time after reset
	always @(posedge ref_clk) begin
		if (rst) begin
			wait_cnt <= 0;
		end else if (wait_cnt < int'(BOOT_CYC)) begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	assign mgmt_ok = (wait_cnt == int'(BOOT_CYC));
endmodule // phymt_mac_model
`default_nettype wire

// *** tb/phymt_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module phymt_core_tb;
	import phymt_pkg::*;
	// Short test counts; expectations below derive from these
	localparam logic [31:0] T_JAB = 32'h0000_00c8;
	localparam logic [31:0] T_UNJAB = 32'h0000_012c;
	localparam logic [31:0] T_GAP = 32'h0000_01f4;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic link_clk, tx_en, tx_go, mgmt_ok, rx_nib_rdy;
	phymt_pin_type drv, pins;
	phymt_mii_type mii;
	phymt_line_type line;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;

	always #50 ref_clk = ~ref_clk;
	always_comb begin
		pins = drv;
		pins.link_clk = link_clk;
		pins.tx_en = tx_en;
	end
	phymt_core #(.JAB_CYC(T_JAB), .UNJAB_CYC(T_UNJAB), .FLP_GAP_CYC(T_GAP),
		.FIFO_DEPTH(RX_FIFO_DEPTH)) i_dut (.ref_clk(ref_clk), .rst(rst), .pins(pins),
		.mii(mii), .line(line), .rx_nib_rdy(rx_nib_rdy));
	phymt_mac_model i_mac (.ref_clk(ref_clk), .rst(rst), .tx_go(tx_go), .mii(mii),
		.link_clk(link_clk), .tx_en(tx_en), .mgmt_ok(mgmt_ok));

	task automatic results();
		if (bad_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Whole run is about 24000 cycles
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count = bad_count + 1;
			results();
		end
	end
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_nib(input logic [NIB_W-1:0] got, input logic [NIB_W-1:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask
	function automatic logic pick(input int sel);
		case (sel)
			0: return mii.crs;
			1: return mii.col;
			2: return mii.rx_dv;
			3: return line.tp_tx;
			4: return line.jabber;
			5: return line.mgmt_ready;
			6: return line.link_pulse;
			default: return tx_en;
		endcase
	endfunction
	task automatic neg(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Cycles until the picked signal reaches v, checked against lo..hi
	task automatic meas(input int sel, input logic v, input int lo, input int hi);
		int n;
		n = 0;
		while (pick(sel) !== v && n <= hi) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk_rng(n, lo, hi);
	endtask
	// Strobe spacing of three cycles, one more than the fastest the edge detector takes
	task automatic push(input logic [NIB_W-1:0] nib);
		neg(1);
		drv.rx_nib = nib;
		drv.rx_nib_stb = 1'b1;
		neg(1);
		drv.rx_nib_stb = 1'b0;
		neg(1);
	endtask
	task automatic t_boot();
		chk_bit(line.mgmt_ready, 1'b0);
		chk_bit(mii.crs, 1'b0);
		chk_bit(rx_nib_rdy, 1'b1);
		chk_bit(mgmt_ok, 1'b0);
		meas(5, 1'b1, int'(BOOT_CYC) - 4, int'(BOOT_CYC) + 4);
		chk_bit(mgmt_ok, 1'b1);
	endtask
	task automatic t_rx10();
		int t0;
		neg(1);
		drv.rx_act = 1'b1;
		meas(0, 1'b1, CH_ON[CH_RXCRS] + 2, CH_ON[CH_RXCRS] + 5);
		t0 = cyc;
		for (int i = 0; i < 17; i++) begin
			if (i == 16) begin
				neg(2);
				chk_bit(rx_nib_rdy, 1'b0);
			end
			push(i[3:0]);
		end
		meas(2, 1'b1, 0, 40);
		chk_rng(cyc - t0, int'(RX_SFD_CYC), int'(RX_SFD_CYC) + 12);
		neg(1);
		drv.rx_act = 1'b0;
		meas(2, 1'b0, 118, 136);
		chk_bit(mii.crs, 1'b1);
		meas(0, 1'b0, 1, 1);
		chk_rng(i_mac.got_q.size(), 16, 16);
		foreach (i_mac.got_q[k]) chk_nib(i_mac.got_q[k], k[3:0]);
		i_mac.got_q.delete();
	endtask
	task automatic t_rx_pre();
		neg(1);
		drv.cfg_pre = 1'b1;
		drv.cfg_ext = 1'b1;
		drv.rx_act = 1'b1;
		meas(0, 1'b1, CH_ON[CH_RXCRS] + 2, CH_ON[CH_RXCRS] + 5);
		push(4'ha);
		push(4'h5);
		meas(2, 1'b1, 0, 16);
		neg(1);
		drv.rx_act = 1'b0;
		meas(2, 1'b0, 0, 24);
		meas(0, 1'b0, 0, 1);
		chk_rng(i_mac.got_q.size(), 2, 2);
		chk_nib(i_mac.got_q[0], 4'ha);
		chk_nib(i_mac.got_q[1], 4'h5);
		i_mac.got_q.delete();
	endtask
	task automatic t_tx10();
		neg(1);
		drv.sqe_en = 1'b1;
		tx_go = 1'b1;
		meas(7, 1'b1, 0, 10);
		meas(0, 1'b1, CH_ON[CH_TXCRS] + 2, CH_ON[CH_TXCRS] + 14);
		meas(3, 1'b1, 0, 2);
		chk_bit(mii.col, 1'b0);
		neg(10);
		tx_go = 1'b0;
		meas(7, 1'b0, 0, 10);
		meas(1, 1'b1, int'(HB_DLY_CYC), 28);
		meas(1, 1'b0, int'(HB_LEN_CYC), 15);
		chk_bit(mii.crs, 1'b0);
		chk_bit(line.tp_tx, 1'b0);
		neg(1);
		drv.sqe_en = 1'b0;
	endtask
	task automatic t_col10();
		neg(1);
		drv.rx_col = 1'b1;
		meas(1, 1'b1, CH_ON[CH_COL] + 2, CH_ON[CH_COL] + 5);
		neg(1);
		drv.rx_col = 1'b0;
		meas(1, 1'b0, CH_OFF[CH_COL] + 2, CH_OFF[CH_COL] + 5);
	endtask
	// First stream alone, then one that collides with our transmission
	task automatic t_fx();
		neg(1);
		drv.mode_fx = 1'b1;
		for (int k = 0; k < 2; k++) begin
			tx_go = k[0];
			neg(12);
			drv.fx_j = 1'b1;
			meas(0, 1'b1, CH_ON[CH_FXCRS] + 2, CH_ON[CH_FXCRS] + 5);
			chk_bit(mii.col, k[0]);
			neg(1);
			drv.fx_j = 1'b0;
			// Valid stands one cycle at 100M, so it is judged here, not by the MAC
			if (k == 0) begin
				push(4'h3);
				meas(2, 1'b1, 1, 3);
				chk_nib(mii.rxd, 4'h3);
			end
			neg(4);
			drv.fx_t = 1'b1;
			meas(0, 1'b0, CH_OFF[CH_FXCRS] + 2, CH_OFF[CH_FXCRS] + 5);
			chk_bit(mii.col, 1'b0);
			neg(1);
			drv.fx_t = 1'b0;
		end
		tx_go = 1'b0;
		neg(12);
		drv.mode_fx = 1'b0;
	endtask
	task automatic t_jab();
		int t0;
		neg(1);
		tx_go = 1'b1;
		meas(7, 1'b1, 0, 10);
		meas(4, 1'b1, int'(T_JAB), int'(T_JAB) + 16);
		t0 = cyc;
		neg(8);
		chk_bit(line.tp_tx, 1'b0);
		chk_bit(mii.col, 1'b1);
		tx_go = 1'b0;
		meas(4, 1'b0, 0, int'(T_UNJAB) + 4);
		chk_rng(cyc - t0, int'(T_UNJAB), int'(T_UNJAB) + 2);
	endtask
	task automatic t_flp();
		int ts[$];
		int w;
		logic prev;
		neg(1);
		drv.flp_word = 16'h8421;
		drv.an_en = 1'b1;
		meas(6, 1'b1, 0, int'(T_GAP) + 20);
		prev = 1'b0;
		w = 0;
		for (int i = 0; i < 17 * int'(FLP_CLK_CYC) + 40; i++) begin
			if (line.link_pulse === 1'b1 && prev !== 1'b1) ts.push_back(cyc);
			if (line.link_pulse === 1'b1 && ts.size() == 1) w++;
			prev = line.link_pulse;
			@(posedge ref_clk);
			#1;
		end
		chk_rng(ts.size(), 21, 21);
		chk_rng(w, int'(FLP_PW_CYC), int'(FLP_PW_CYC) + 1);
		chk_rng(ts[1] - ts[0], int'(FLP_DATA_CYC), int'(FLP_DATA_CYC));
		chk_rng(ts[2] - ts[0], int'(FLP_CLK_CYC), int'(FLP_CLK_CYC));
		chk_rng(ts[20] - ts[0], 16 * int'(FLP_CLK_CYC), 16 * int'(FLP_CLK_CYC));
		meas(6, 1'b1, 0, int'(T_GAP) + 1200);
		chk_rng(cyc - ts[20], int'(T_GAP), int'(T_GAP) + int'(FLP_CLK_CYC) + 4);
		neg(1);
		drv.an_en = 1'b0;
	endtask
	initial begin
		drv = '0;
		tx_go = 1'b0;
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		t_boot();
		t_rx10();
		t_rx_pre();
		t_tx10();
		t_col10();
		t_fx();
		t_jab();
		t_flp();
		results();
	end
endmodule // phymt_core_tb
`default_nettype wire
